// ---- design/pixel_capture_pkg.sv ----
// constants and types shared by the pixel input capture block
// assumes a single 250 MHz system clock; no registers reachable by software
package pixel_capture_pkg;

    // ************************************************************
    // widths and depths
    // ************************************************************
    localparam int PD_W = 12;
    localparam int BYTE_W = 8;
    localparam int PIX_W = 24;
    localparam int FMT_W = 3;
    localparam int FIFO_DEPTH = 8;

    // ************************************************************
    // input format codes
    // ************************************************************
    localparam logic [2:0] FMT_RGB888 = 3'h0;
    localparam logic [2:0] FMT_RGB555 = 3'h1;
    localparam logic [2:0] FMT_RGB565 = 3'h2;
    localparam logic [2:0] FMT_YUV422_DDR = 3'h3;
    localparam logic [2:0] FMT_YUV422_SDR = 3'h4;

    // ************************************************************
    // capture phase, gray coded along the normal walk
    // ************************************************************
    typedef enum logic [1:0]
    {
        PH_A = 2'h0,
        PH_B = 2'h1,
        PH_C = 2'h3,
        PH_D = 2'h2
    } phase_t;

endpackage

// ---- design/graphics_pixel_input_capture.sv ----
// pixel input capture: samples the controller's pixel clock and data pins,
// rebuilds pixels per format and queues them in an 8 word fifo
// assumes pixel clock far below clock/2 and format changes only while
// capture_enable is low
// Operation
// RL1: edge select picks edge of first half-word
// RL2: slot select picks which pin group first
// RL3: format 0 maps 24-bit RGB/YCbCr over edges
// RL4: format 1 maps 5:5:5 on low byte
// RL5: format 2 maps 5:6:5 on low byte
// RL6: format 3 gives Cb,Y0,Cr,Y1 on both edges
// RL7: format 4 gives Cb,Y0,Cr,Y1 on rising edges
// RL8: unused pins never reach the assembled pixel
`timescale 1ns/1ps

module pixel_fifo
#(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic out_valid_r;
    logic [WIDTH-1:0] out_data_r;

    wire wr_en = in_valid && in_ready;
    // output stage refills whenever it is empty or being drained
    wire ld_en = (count_r != '0) && (!out_valid_r || out_ready);
    wire [AW-1:0] wr_ptr_inc = (wr_ptr_r == AW'(DEPTH - 1)) ? '0
                                                           : wr_ptr_r + 1'b1;
    wire [AW-1:0] rd_ptr_inc = (rd_ptr_r == AW'(DEPTH - 1)) ? '0
                                                           : rd_ptr_r + 1'b1;

    assign in_ready = (count_r != CW'(DEPTH));
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;
    assign count_nxt = (wr_en && !ld_en) ? count_r + 1'b1
                     : (!wr_en && ld_en) ? count_r - 1'b1
                     : count_r;

    always_ff @(posedge clock)
    begin
        if (wr_en)
            mem[wr_ptr_r] <= in_data;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            wr_ptr_r <= wr_en ? wr_ptr_inc : wr_ptr_r;
            rd_ptr_r <= ld_en ? rd_ptr_inc : rd_ptr_r;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end
        else if (ld_en)
        begin
            out_valid_r <= 1'b1;
            out_data_r <= mem[rd_ptr_r];
        end
        else if (out_ready)
        begin
            out_valid_r <= 1'b0;
        end
    end
endmodule

module graphics_pixel_input_capture
(
    input wire logic clock,
    input wire logic rst,
    input wire logic pixel_clk_in,
    input wire logic [pixel_capture_pkg::PD_W-1:0] pixel_data_in,
    input wire logic capture_enable,
    input wire logic [pixel_capture_pkg::FMT_W-1:0] input_format,
    input wire logic capture_edge_select,
    input wire logic first_word_select,
    output logic [pixel_capture_pkg::PIX_W-1:0] pixel_out,
    output logic pixel_valid,
    input wire logic pixel_ready,
    output logic overflow
);
    // ************************************************************
    // pin synchronisers and edge detection
    // ************************************************************
    logic pclk_meta_r;
    logic pclk_sync_r;
    logic pclk_prev_r;
    logic [pixel_capture_pkg::PD_W-1:0] din_meta_r;
    logic [pixel_capture_pkg::PD_W-1:0] din_sync_r;

    // data takes the same two stages as the clock so they stay aligned
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pclk_meta_r <= 1'b0;
            pclk_sync_r <= 1'b0;
            pclk_prev_r <= 1'b0;
            din_meta_r <= '0;
            din_sync_r <= '0;
        end
        else
        begin
            pclk_meta_r <= pixel_clk_in;
            pclk_sync_r <= pclk_meta_r;
            pclk_prev_r <= pclk_sync_r;
            din_meta_r <= pixel_data_in;
            din_sync_r <= din_meta_r;
        end
    end

    wire rise = pclk_sync_r && !pclk_prev_r;
    wire fall = !pclk_sync_r && pclk_prev_r;

    // ************************************************************
    // phase walk and edge choice
    // ************************************************************
    pixel_capture_pkg::phase_t phase_r;
    pixel_capture_pkg::phase_t phase_nxt;

    wire fmt_ddr = (input_format == pixel_capture_pkg::FMT_YUV422_DDR);
    wire fmt_sdr = (input_format == pixel_capture_pkg::FMT_YUV422_SDR);
    wire fmt_yuv = fmt_ddr || fmt_sdr;
    wire fmt_half = (input_format == pixel_capture_pkg::FMT_RGB888)
                 || (input_format == pixel_capture_pkg::FMT_RGB555)
                 || (input_format == pixel_capture_pkg::FMT_RGB565);
    wire ph_a = (phase_r == pixel_capture_pkg::PH_A);
    wire ph_b = (phase_r == pixel_capture_pkg::PH_B);
    wire ph_c = (phase_r == pixel_capture_pkg::PH_C);
    wire ph_d = (phase_r == pixel_capture_pkg::PH_D);
    wire odd_phase = ph_b || ph_d;
    // half-word formats: first word on rise when edge select is 0
    wire want_half = odd_phase ^ !capture_edge_select; // RL1
    wire want_rise = fmt_sdr ? 1'b1 // RL7
                   : fmt_ddr ? odd_phase // RL6
                   : want_half;
    wire take = capture_enable && (fmt_half || fmt_yuv)
             && (want_rise ? rise : fall);
    wire last = fmt_half ? ph_b : ph_d;
    wire push = take && (fmt_half ? ph_b : (ph_c || ph_d));

    always_comb
    begin
        case (phase_r)
            pixel_capture_pkg::PH_A: phase_nxt = pixel_capture_pkg::PH_B;
            pixel_capture_pkg::PH_B: phase_nxt = pixel_capture_pkg::PH_C;
            pixel_capture_pkg::PH_C: phase_nxt = pixel_capture_pkg::PH_D;
            pixel_capture_pkg::PH_D: phase_nxt = pixel_capture_pkg::PH_A;
            default: phase_nxt = pixel_capture_pkg::PH_A;
        endcase
        if (last)
        begin
            phase_nxt = pixel_capture_pkg::PH_A;
        end
    end

    // enable low realigns the walk; there is no sync word to lock onto
    always_ff @(posedge clock)
    begin
        if (rst || !capture_enable)
        begin
            phase_r <= pixel_capture_pkg::PH_A;
        end
        else if (take)
        begin
            phase_r <= phase_nxt;
        end
    end

    // ************************************************************
    // holding registers
    // ************************************************************
    logic [pixel_capture_pkg::PD_W-1:0] hw0_r;
    logic [pixel_capture_pkg::BYTE_W-1:0] cb_r;
    logic [pixel_capture_pkg::BYTE_W-1:0] y0_r;
    logic [pixel_capture_pkg::BYTE_W-1:0] cr_r;
    wire [pixel_capture_pkg::BYTE_W-1:0] byte_in = din_sync_r[7:0]; // RL8

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            hw0_r <= '0;
            cb_r <= '0;
            y0_r <= '0;
            cr_r <= '0;
        end
        else if (take)
        begin
            hw0_r <= (fmt_half && ph_a) ? din_sync_r : hw0_r;
            cb_r <= (fmt_yuv && ph_a) ? byte_in : cb_r; // RL6 RL7
            y0_r <= (fmt_yuv && ph_b) ? byte_in : y0_r;
            cr_r <= (fmt_yuv && ph_c) ? byte_in : cr_r;
        end
    end

    // ************************************************************
    // pixel assembly, output as {R,G,B} or {Cr,Y,Cb}
    // ************************************************************
    wire [pixel_capture_pkg::PD_W-1:0] g3_grp = first_word_select
                                               ? din_sync_r : hw0_r; // RL2
    wire [pixel_capture_pkg::PD_W-1:0] r7_grp = first_word_select
                                               ? hw0_r : din_sync_r; // RL2
    wire [pixel_capture_pkg::PIX_W-1:0] pix_888 =
        {r7_grp[11:4], r7_grp[3:0], g3_grp[11:8], g3_grp[7:0]}; // RL3
    // unused pins (bit 7 of the red-group word, upper group) are dropped
    wire [pixel_capture_pkg::PIX_W-1:0] pix_555 =
        {3'h0, r7_grp[6:2], 3'h0, r7_grp[1:0], g3_grp[7:5],
         3'h0, g3_grp[4:0]}; // RL4 RL8
    wire [pixel_capture_pkg::PIX_W-1:0] pix_565 =
        {3'h0, r7_grp[7:3], 2'h0, r7_grp[2:0], g3_grp[7:5],
         3'h0, g3_grp[4:0]}; // RL5 RL8
    // chroma of a pair is shared by both lumas
    wire [pixel_capture_pkg::PIX_W-1:0] pix_yuv = ph_c
        ? {byte_in, y0_r, cb_r}
        : {cr_r, byte_in, cb_r}; // RL6 RL7
    wire [pixel_capture_pkg::PIX_W-1:0] push_data =
        (input_format == pixel_capture_pkg::FMT_RGB888) ? pix_888
        : (input_format == pixel_capture_pkg::FMT_RGB555) ? pix_555
        : (input_format == pixel_capture_pkg::FMT_RGB565) ? pix_565
        : pix_yuv;

    // ************************************************************
    // queue and overflow
    // ************************************************************
    logic fifo_in_ready;
    logic overflow_r;

    pixel_fifo
    #(
        .WIDTH(pixel_capture_pkg::PIX_W),
        .DEPTH(pixel_capture_pkg::FIFO_DEPTH)
    )
    u_fifo
    (
        .clock(clock),
        .rst(rst),
        .in_valid(push),
        .in_data(push_data),
        .in_ready(fifo_in_ready),
        .out_valid(pixel_valid),
        .out_data(pixel_out),
        .out_ready(pixel_ready)
    );

    // the pins cannot be stalled, so a full queue loses the pixel
    wire overflow_nxt = overflow_r || (push && !fifo_in_ready);
    always_ff @(posedge clock)
    begin
        overflow_r <= (rst || !capture_enable) ? 1'b0 : overflow_nxt;
    end
    assign overflow = overflow_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb_main @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_FIRST_EDGE: assert property ( // RL1
        take && fmt_half && ph_a |-> rise == !capture_edge_select)
        else $error("first half-word on wrong edge");
    AST_SECOND_EDGE: assert property ( // RL1
        take && fmt_half && ph_b |-> rise == capture_edge_select)
        else $error("second half-word on wrong edge");
    AST_SLOT_GREEN_FIRST: assert property ( // RL2
        push && input_format == pixel_capture_pkg::FMT_RGB888
        && !first_word_select |-> push_data[11:0] == hw0_r)
        else $error("green group not taken first");
    AST_SLOT_RED_FIRST: assert property ( // RL2
        push && input_format == pixel_capture_pkg::FMT_RGB888
        && first_word_select |-> push_data[23:16] == hw0_r[11:4])
        else $error("red group not taken first");
    AST_FMT0_MAP: assert property ( // RL3
        push && input_format == pixel_capture_pkg::FMT_RGB888
        && !first_word_select |-> push_data[23:12] == din_sync_r
        && push_data[7:0] == hw0_r[7:0])
        else $error("format 0 bit mapping wrong");
    AST_FMT1_MAP: assert property ( // RL4
        push && input_format == pixel_capture_pkg::FMT_RGB555
        |-> push_data[23:21] == 3'h0 && push_data[15:13] == 3'h0)
        else $error("format 1 unused bits not zero");
    AST_FMT2_MAP: assert property ( // RL5
        push && input_format == pixel_capture_pkg::FMT_RGB565
        && !first_word_select |-> push_data[20:16] == din_sync_r[7:3]
        && push_data[4:0] == hw0_r[4:0])
        else $error("format 2 bit mapping wrong");
    AST_FMT3_EDGES: assert property ( // RL6
        take && fmt_ddr |-> rise == odd_phase)
        else $error("format 3 byte on wrong edge");
    AST_FMT4_RISE: assert property ( // RL7
        take && fmt_sdr |-> rise)
        else $error("format 4 byte taken on falling edge");
    AST_NARROW_HIGH: assert property ( // RL8
        push && fmt_yuv && ph_d |-> push_data[15:8] == din_sync_r[7:0]
        && push_data[23:16] == cr_r)
        else $error("narrow format used wrong pins");
    AST_PIXEL_OUT: assert property (
        push && fifo_in_ready && !pixel_valid |-> ##[1:3] pixel_valid)
        else $error("pushed pixel never reached output");

    COV_FMT0: cover property (
        push && input_format == pixel_capture_pkg::FMT_RGB888);
    COV_FMT3: cover property (push && fmt_ddr && ph_d);
    COV_FMT4: cover property (push && fmt_sdr && ph_d);
    COV_OVERFLOW: cover property (push && !fifo_in_ready);
endmodule

// ---- verification/pixel_host_model.sv ----
// host controller model: drives the pixel clock and data pins
// assumes the bench calls one task at a time; link clock period 32 ns
`timescale 1ns/1ps
module pixel_host_model
(
    output logic clk_out,
    output logic [11:0] data_out
);
    initial
    begin
        clk_out = 1'b0;
        data_out = 12'hA5A;
    end
    // clock stands still between frames at the chosen idle level
    task automatic park(input logic lvl);
        clk_out = lvl;
    endtask
    // 32 ns link period: data leads and trails each used edge by
    // 8 ns on both-edge formats, 16 ns on rising-only
    task automatic send(input logic [11:0] w, input logic sdr);
        data_out = w;
        if (sdr)
        begin
            #16;
            clk_out = 1'b1;
            #16;
            clk_out = 1'b0;
        end
        else
        begin
            #8;
            clk_out = ~clk_out;
            #8;
        end
    endtask
    // released pins show the inverse, never the stale word
    task automatic done();
        data_out = ~data_out;
    endtask
endmodule

// ---- verification/test_graphics_pixel_input_capture.sv ----
// bench for the pixel input capture block
// assumes the host model in pixel_host_model.sv
`timescale 1ns/1ps
module test_graphics_pixel_input_capture;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic capture_enable = 1'b0;
    logic [pixel_capture_pkg::FMT_W-1:0] input_format = 3'h0;
    logic capture_edge_select = 1'b0;
    logic first_word_select = 1'b0;
    logic pixel_ready = 1'b1;
    logic pixel_clk_in;
    logic [pixel_capture_pkg::PD_W-1:0] pixel_data_in;
    logic [pixel_capture_pkg::PIX_W-1:0] pixel_out;
    logic pixel_valid;
    logic overflow;
    logic [23:0] got[$];
    int n_mismatch = 0;
    int total_checks = 0;

    always #2 clock = ~clock;

    graphics_pixel_input_capture u_graphics_pixel_input_capture
    (
        .clock(clock), .rst(rst), .pixel_clk_in(pixel_clk_in),
        .pixel_data_in(pixel_data_in), .capture_enable(capture_enable),
        .input_format(input_format),
        .capture_edge_select(capture_edge_select),
        .first_word_select(first_word_select), .pixel_out(pixel_out),
        .pixel_valid(pixel_valid), .pixel_ready(pixel_ready),
        .overflow(overflow)
    );
    pixel_host_model u_pixel_host_model
    (
        .clk_out(pixel_clk_in),
        .data_out(pixel_data_in)
    );

    // sampled mid-cycle so the edge's own updates have landed
    always @(negedge clock)
        if (pixel_valid === 1'b1 && pixel_ready === 1'b1)
            got.push_back(pixel_out);

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic expect_pix(input logic [23:0] exp);
        for (int i = 0; i < 200 && got.size() == 0; i++)
        begin
            @(posedge clock);
            #0.5;
        end
        check(got.size() > 0 ? got.pop_front() : ~exp, exp);
    endtask
    // controls only move while capture is off
    task automatic setup(input logic [2:0] f, input logic es, input logic sl,
        input logic idle);
        @(posedge clock);
        #0.5 capture_enable = 1'b0;
        input_format = f;
        capture_edge_select = es;
        first_word_select = sl;
        u_pixel_host_model.park(idle);
        repeat (8) @(posedge clock);
        #0.5 capture_enable = 1'b1;
        repeat (4) @(posedge clock);
        #0.5;
    endtask
    task automatic pair(input logic [11:0] a, input logic [11:0] b);
        u_pixel_host_model.send(a, 1'b0);
        u_pixel_host_model.send(b, 1'b0);
    endtask

    task automatic t_slot_edge();
        logic [7:0] r, g, b;
        for (int k = 0; k < 4; k++)
        begin
            setup(3'h0, k[1], k[0], k[1]);
            for (int j = 0; j < 2; j++)
            begin
                r = 8'h96 ^ 8'(k);
                g = 8'h5A ^ 8'(j);
                b = 8'hE1 ^ 8'(k * 16 + j);
                if (k[0])
                    pair({r, g[7:4]}, {g[3:0], b});
                else
                    pair({g[3:0], b}, {r, g[7:4]});
                expect_pix({r, g, b});
            end
            u_pixel_host_model.done();
        end
        $display("test slot_edge done");
    endtask

    task automatic t_narrow();
        // unused pins carry junk that must not leak into the pixel
        setup(3'h1, 1'b1, 1'b0, 1'b1);
        pair({4'hF, 3'h6, 5'h19}, {4'hA, 1'b1, 5'h13, 2'h1});
        u_pixel_host_model.done();
        expect_pix({8'h13, 8'h0E, 8'h19});
        setup(3'h2, 1'b1, 1'b0, 1'b1);
        pair({4'h5, 3'h5, 5'h07}, {4'hC, 5'h1B, 3'h5});
        u_pixel_host_model.done();
        expect_pix({8'h1B, 8'h2D, 8'h07});
        $display("test narrow done");
    endtask

    task automatic t_422(input logic [2:0] f);
        logic sdr;
        sdr = (f == 3'h4);
        // selects set opposite to their defaults: 4:2:2 ignores them
        setup(f, 1'b1, 1'b1, ~sdr);
        u_pixel_host_model.send(12'hF3C, sdr);
        u_pixel_host_model.send(12'h781, sdr);
        u_pixel_host_model.send(12'hAC4, sdr);
        u_pixel_host_model.send(12'h5EB, sdr);
        u_pixel_host_model.done();
        expect_pix({8'hC4, 8'h81, 8'h3C});
        expect_pix({8'hC4, 8'hEB, 8'h3C});
        $display("test 422 format %0d done", f);
    endtask

    task automatic t_fill();
        setup(3'h0, 1'b0, 1'b0, 1'b0);
        pixel_ready = 1'b0;
        for (int i = 0; i < 10; i++)
            pair({4'h1, 8'(i)}, {8'h42 + 8'(i), 4'h7});
        u_pixel_host_model.done();
        repeat (20) @(posedge clock);
        check({23'h0, overflow}, 24'h1);
        #0.5 pixel_ready = 1'b1;
        // 8 queued plus the output stage; the tenth was dropped
        for (int i = 0; i < 9; i++)
            expect_pix({8'h42 + 8'(i), 8'h71, 8'(i)});
        repeat (20) @(posedge clock);
        check(24'(got.size()), 24'h0);
        #0.5 capture_enable = 1'b0;
        repeat (3) @(posedge clock);
        check({23'h0, overflow}, 24'h0);
        $display("test fill done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clock);
        #0.5 rst = 1'b0;
        t_slot_edge();
        t_narrow();
        t_422(3'h3);
        t_422(3'h4);
        t_fill();
        end_sim();
    end
    // whole run needs a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule
